/* logic/cangrs_top.sv */
// CAN general register set: flags, enables, control/status, bit timing, bank select, last identifier.
//
// Operation
// RULE1: Receive flag per buffer, cleared by zero or ready
// RULE2: Transmit-done flag set on success, software clears
// RULE3: Status flag: standby dominant, passive toggle, errors
// RULE4: Overrun flag set when no buffer free
// RULE5: Transmit-error flag set on send error
// RULE6: Error pending equals OR of three flags
// RULE7: Writing zero clears an interrupt flag
// RULE8: Software clears by mask, never read-modify-write
// RULE9: Extended enable makes receive errors set status
// RULE10: Each request gated by its enable bit
// RULE11: Bus-off while transmit count exceeds 255
// RULE12: Error-passive only when passive, not bus-off
// RULE13: Self-reception keeps own filtered frames, else discard
// RULE14: No-retry stops error retries, not arbitration
// RULE15: Leaving standby waits 11 or 128x11 recessive
// RULE16: Wake pulse drives dominant bit leaving standby
// RULE17: Run reads one until standby reached
// RULE18: Quantum is clock times prescale plus one
// RULE19: Segment lengths value plus one; reset 23h
// RULE20: Timing registers writable only in standby
// RULE21: Three-bit page selects paged window bank
// RULE22: Last identifier captures id, remote, length
// RULE23: Overrun identifier kept until newer one arrives
// RULE24: Writing one leaves flag; reserved bits zero
// RULE25: Interrupt output follows any enabled flag
`timescale 1ns/1ps
`include "cangrs_consts.svh"

module cangrs_top
	import cangrs_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire cangrs_events_t       core_events,
	input  wire logic                 frame_header_valid,
	input  wire cangrs_header_t       frame_header,
	input  wire logic                 own_frame,
	input  wire logic                 transfer_busy,
	input  wire logic                 bus_bit_tick,
	input  wire logic                 bus_recessive,
	input  wire logic [8:0]           tx_error_count,
	input  wire logic                 tx_lost_arbitration,
	input  wire logic                 tx_failed_error,
	output logic                      irq,
	output logic                      quantum_tick,
	output logic [1:0]                sync_jump_width,
	output logic [3:0]                segment_one_len,
	output logic [2:0]                segment_two_len,
	output logic [2:0]                bank_page,
	output logic                      bank_access,
	output logic                      core_running,
	output logic                      wake_dominant,
	output logic                      self_receive_keep,
	output logic                      tx_retry
);

	// ----------------------------------------------------------------
	// Register state
	// Software state comes first; the rest tracks flag edges,
	// the quantum divider and the walk out of standby.
	// ----------------------------------------------------------------
	logic [7:0]    flags_q;
	logic [7:0]    enables_q;
	logic [4:1]    ctrl_q;
	logic          run_req_q;
	logic [7:0]    prescale_q;
	logic [6:0]    segtime_q;
	logic [2:0]    bank_q;
	logic [7:0]    lid_high_q;
	logic [7:0]    lid_low_q;
	logic [2:0]    buf_rdy_q;
	logic          passive_q;
	logic [5:0]    quantum_cnt_q;
	logic [3:0]    rec_run_q;
	logic [7:0]    seq_cnt_q;
	logic          quantum_tick_q;
	cangrs_state_t state_q;
	cangrs_state_t state_d;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Each register is one aligned word with its bits in the low byte.
	// Decodes are exact, so an unmapped write hits nothing.
	function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
		hit = (addr == off);
	endfunction

	wire logic acc        = psel && penable;
	wire logic wr         = acc && pwrite;
	wire logic wr_flags   = wr && hit(paddr, `CANGRS_OFF_FLAGS);
	wire logic wr_enables = wr && hit(paddr, `CANGRS_OFF_ENABLES);
	wire logic wr_ctrl    = wr && hit(paddr, `CANGRS_OFF_CTRL);
	wire logic wr_pre     = wr && hit(paddr, `CANGRS_OFF_PRESCALE);
	wire logic wr_seg     = wr && hit(paddr, `CANGRS_OFF_SEGTIME);
	wire logic wr_bank    = wr && hit(paddr, `CANGRS_OFF_BANK);
	wire logic wr_lidh    = wr && hit(paddr, `CANGRS_OFF_LID_HIGH);
	wire logic wr_lidl    = wr && hit(paddr, `CANGRS_OFF_LID_LOW);
	wire logic wr_rdy     = wr && hit(paddr, `CANGRS_OFF_BUF_RDY);
	wire logic in_window  = paddr[11:6] == 6'h01;
	wire logic mapped     = (paddr[11:6] == 6'h00) && (paddr[5:2] <= 4'h8) && (paddr[1:0] == 2'b00);
	wire logic in_standby = (state_q == CANGRS_STANDBY);

	// The slave always answers in the first access cycle.
	// The paged window is served elsewhere, so it is no error here.
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped && !in_window;

	// ----------------------------------------------------------------
	// Flag set and clear terms
	// ----------------------------------------------------------------
	// Bus-off is decoded first, because error passive excludes it.
	wire logic       bus_off     = tx_error_count >= `CANGRS_TEC_BUSOFF; // RULE11
	wire logic       passive_now = (tx_error_count >= `CANGRS_TEC_PASSIVE) && !bus_off; // RULE12
	wire logic [2:0] rx_set      = core_events.rx_stored;
	wire logic [2:0] rdy_clear   = wr_rdy ? ~pwdata[2:0] & buf_rdy_q : 3'b000;
	// In standby a dominant bit takes the place of the passive toggle;
	// it doubles as the wake-up report.
	wire logic       status_set  = (in_standby && core_events.dominant_seen)      // RULE3
		|| (!in_standby && (passive_now != passive_q))
		|| (enables_q[6] && core_events.rx_error);                           // RULE9
	wire logic [7:1] set_vec     = {rx_set[2], rx_set[1], rx_set[0], core_events.tx_done, // RULE1 RULE2
		status_set, core_events.overrun, core_events.tx_error};                  // RULE4 RULE5
	// A zero written clears; a one leaves the flag alone; a set in the same cycle wins.
	wire logic [7:1] clr_vec     = (wr_flags ? ~pwdata[7:1] : 7'h00)              // RULE7 RULE24
		| {rdy_clear[2], rdy_clear[1], rdy_clear[0], 4'h0};                    // RULE1
	wire logic [7:1] flags_d     = (flags_q[7:1] & ~clr_vec) | set_vec;
	// Pending is built from the flags, not stored,
	// so it can never disagree with them.
	wire logic       pend        = |flags_q[3:1];                                 // RULE6

	// Ready bit of a receive buffer tracks its stored message.
	wire logic [2:0] rdy_d       = (buf_rdy_q & ~rdy_clear & ~(wr_flags ? ~pwdata[7:5] : 3'b000)) | rx_set;

	// Sticky flags; software should write a mask, not read-modify-write. RULE8
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q   <= `CANGRS_RST_FLAGS;
			buf_rdy_q <= 3'b000;
			passive_q <= 1'b0;
		end else begin
			flags_q   <= {flags_d, 1'b0};
			buf_rdy_q <= rdy_d;
			passive_q <= passive_now;
		end
	end

	// Kept combinational so that clearing the last flag
	// drops the request in the cycle the write lands.
	// Interrupt line: receive enable gates all three buffer flags. RULE10 RULE25
	assign irq = (|flags_q[7:5] && enables_q[5]) || (flags_q[4] && enables_q[4])
		|| (flags_q[3] && enables_q[3]) || (flags_q[2] && enables_q[2]) || (flags_q[1] && enables_q[1]);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Timing registers lock outside standby to protect a running bus.
	// Such a write is dropped silently; software must see
	// run read as zero before it retimes the node.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enables_q  <= `CANGRS_RST_ENABLES;
			ctrl_q     <= 4'h0;
			prescale_q <= `CANGRS_RST_PRESCALE;
			segtime_q  <= 7'(`CANGRS_RST_SEGTIME);
			bank_q     <= 3'(`CANGRS_RST_BANK);
			run_req_q  <= 1'b0;
		end else begin
			if (wr_enables)
				enables_q <= pwdata[7:0] & `CANGRS_MASK_ENABLES; // RULE24
			if (wr_ctrl) begin
				ctrl_q    <= pwdata[4:1];
				run_req_q <= pwdata[`CANGRS_BIT_RUN];
			end
			if (wr_pre && in_standby)
				prescale_q <= pwdata[7:0]; // RULE20
			if (wr_seg && in_standby)
				segtime_q <= pwdata[6:0]; // RULE20
			if (wr_bank)
				bank_q <= pwdata[2:0]; // RULE21
		end
	end

	// ----------------------------------------------------------------
	// Last identifier capture
	// ----------------------------------------------------------------
	// No reset: the capture means nothing before a frame.
	// A header wins over a software write in one cycle.
	// Every header overwrites, so an overrun identifier stays until the next frame. RULE22 RULE23
	always_ff @(posedge pclk) begin
		if (frame_header_valid) begin
			lid_high_q <= frame_header.ident[10:3];
			lid_low_q  <= {frame_header.ident[2:0], frame_header.remote, frame_header.length};
		end else begin
			if (wr_lidh)
				lid_high_q <= pwdata[7:0];
			if (wr_lidl)
				lid_low_q <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Quantum divider
	// ----------------------------------------------------------------
	// Stopped in standby to save power. RULE18
	// Restarting from zero makes the first quantum
	// after standby a full one.
	wire logic quantum_wrap = quantum_cnt_q == prescale_q[5:0];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quantum_cnt_q  <= 6'h00;
			quantum_tick_q <= 1'b0;
		end else if (in_standby) begin
			quantum_cnt_q  <= 6'h00;
			quantum_tick_q <= 1'b0;
		end else begin
			quantum_cnt_q  <= quantum_wrap ? 6'h00 : quantum_cnt_q + 6'h01;
			quantum_tick_q <= quantum_wrap;
		end
	end

	// ----------------------------------------------------------------
	// Standby state machine
	// ----------------------------------------------------------------
	// Standby is left through an optional wake pulse and a
	// resync that counts runs of recessive bits. Bus-off
	// drops an active node back into resync.
	wire logic run_done   = rec_run_q == `CANGRS_RECESSIVE_RUN - 4'd1;
	wire logic seq_end    = bus_bit_tick && bus_recessive && run_done;
	wire logic fast       = ctrl_q[2] && !bus_off;
	wire logic resync_ok  = seq_end && (fast || seq_cnt_q == `CANGRS_SLOW_SEQS - 8'd1); // RULE15

	// Next state; each state holds until its exit is met.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CANGRS_STANDBY: if (run_req_q) state_d = ctrl_q[1] ? CANGRS_WAKE : CANGRS_RESYNC; // RULE16
			CANGRS_WAKE:    if (bus_bit_tick) state_d = CANGRS_RESYNC;
			CANGRS_RESYNC: begin
				if (!run_req_q)
					state_d = CANGRS_STANDBY;
				else if (resync_ok)
					state_d = CANGRS_ACTIVE;
			end
			CANGRS_ACTIVE: begin
				if (!run_req_q)
					state_d = CANGRS_DRAIN;
				else if (bus_off)
					state_d = CANGRS_RESYNC;
			end
			CANGRS_DRAIN:   if (!transfer_busy) state_d = CANGRS_STANDBY; // RULE17
		endcase
	end

	// Recessive run counter and sequence counter used during resync.
	// Both clear outside resync, so a second wake-up
	// never starts half way through a count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= CANGRS_STANDBY;
			rec_run_q <= 4'h0;
			seq_cnt_q <= 8'h00;
		end else begin
			state_q <= state_d;
			if (state_q != CANGRS_RESYNC) begin
				rec_run_q <= 4'h0;
				seq_cnt_q <= 8'h00;
			end else if (bus_bit_tick) begin
				rec_run_q <= (!bus_recessive || run_done) ? 4'h0 : rec_run_q + 4'h1;
				if (seq_end)
					seq_cnt_q <= seq_cnt_q + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs to the protocol core
	// ----------------------------------------------------------------
	// Timing fields go out straight from their registers;
	// the mode decodes are plain gates.
	assign quantum_tick      = quantum_tick_q;
	assign sync_jump_width   = prescale_q[7:6];
	assign segment_one_len   = segtime_q[3:0]; // RULE19
	assign segment_two_len   = segtime_q[6:4]; // RULE19
	assign bank_page         = bank_q;
	assign bank_access       = acc && in_window;
	assign core_running      = (state_q == CANGRS_ACTIVE) || (state_q == CANGRS_DRAIN);
	assign wake_dominant     = state_q == CANGRS_WAKE;                       // RULE16
	assign self_receive_keep = !own_frame || ctrl_q[4];                      // RULE13
	assign tx_retry          = tx_lost_arbitration || (tx_failed_error && !ctrl_q[3]); // RULE14

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Run reads one until standby is really reached. RULE17
	// Status bits are live, seen as the setup cycle is.
	wire logic       run_read = !in_standby;
	wire logic [7:0] ctrl_rd  = {1'b0, bus_off, passive_now, ctrl_q, run_read}; // RULE11 RULE12
	logic [7:0] rd_byte;
	// Read mux; unmapped and window addresses read zero.
	always_comb begin
		rd_byte = 8'h00;
		if (hit(paddr, `CANGRS_OFF_FLAGS))
			rd_byte = {flags_q[7:1], pend}; // RULE6
		if (hit(paddr, `CANGRS_OFF_ENABLES))
			rd_byte = enables_q;
		if (hit(paddr, `CANGRS_OFF_CTRL))
			rd_byte = ctrl_rd;
		if (hit(paddr, `CANGRS_OFF_PRESCALE))
			rd_byte = prescale_q;
		if (hit(paddr, `CANGRS_OFF_SEGTIME))
			rd_byte = {1'b0, segtime_q};
		if (hit(paddr, `CANGRS_OFF_BANK))
			rd_byte = {5'h00, bank_q};
		if (hit(paddr, `CANGRS_OFF_LID_HIGH))
			rd_byte = lid_high_q;
		if (hit(paddr, `CANGRS_OFF_LID_LOW))
			rd_byte = lid_low_q;
		if (hit(paddr, `CANGRS_OFF_BUF_RDY))
			rd_byte = {5'h00, buf_rdy_q};
	end

	// Read data is caught in the setup cycle and held through
	// the access cycle; the cost is a value one cycle old.
	logic [31:0] prdata_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_q <= 32'h00000000;
		else if (psel && !penable)
			prdata_q <= {24'h000000, rd_byte};
	end

	assign prdata = prdata_q;

endmodule

/* logic/cangrs_consts.svh */
// Register offsets, field positions, reset values and timing counts of the CAN general register set.
`ifndef CANGRS_CONSTS_SVH
`define CANGRS_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte addresses on the APB bus
// ----------------------------------------------------------------
`define CANGRS_OFF_FLAGS     12'h000
`define CANGRS_OFF_ENABLES   12'h004
`define CANGRS_OFF_CTRL      12'h008
`define CANGRS_OFF_PRESCALE  12'h00C
`define CANGRS_OFF_SEGTIME   12'h010
`define CANGRS_OFF_BANK      12'h014
`define CANGRS_OFF_LID_HIGH  12'h018
`define CANGRS_OFF_LID_LOW   12'h01C
`define CANGRS_OFF_BUF_RDY   12'h020

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CANGRS_BIT_TXDONE    4
`define CANGRS_BIT_STATUS    3
`define CANGRS_BIT_OVERRUN   2
`define CANGRS_BIT_TXERR     1
`define CANGRS_BIT_PEND      0
`define CANGRS_BIT_RUN       0

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define CANGRS_RST_FLAGS     8'h00
`define CANGRS_RST_ENABLES   8'h00
`define CANGRS_RST_CTRL      8'h00
`define CANGRS_RST_PRESCALE  8'h00
`define CANGRS_RST_SEGTIME   8'h23
`define CANGRS_RST_BANK      8'h00
`define CANGRS_MASK_ENABLES  8'h7E
`define CANGRS_MASK_CTRL     8'h1F
`define CANGRS_MASK_SEGTIME  8'h7F
`define CANGRS_MASK_BANK     8'h07

// ----------------------------------------------------------------
// Resynchronisation counts and transmit error-count thresholds
// ----------------------------------------------------------------
`define CANGRS_RECESSIVE_RUN 4'd11
`define CANGRS_SLOW_SEQS     8'd128
`define CANGRS_TEC_BUSOFF    9'd256
`define CANGRS_TEC_PASSIVE   9'd128

`endif

/* logic/cangrs_pkg.sv */
// Types shared by the CAN general register set.
package cangrs_pkg;

	// Node state sequence around standby.
	typedef enum logic [2:0] {
		CANGRS_STANDBY,
		CANGRS_WAKE,
		CANGRS_RESYNC,
		CANGRS_ACTIVE,
		CANGRS_DRAIN
	} cangrs_state_t;

	// Events reported by the protocol core, each a one-cycle pulse.
	typedef struct packed {
		logic [2:0] rx_stored;
		logic       tx_done;
		logic       tx_error;
		logic       rx_error;
		logic       overrun;
		logic       dominant_seen;
	} cangrs_events_t;

	// Header of a frame seen on the bus.
	typedef struct packed {
		logic [10:0] ident;
		logic        remote;
		logic [3:0]  length;
	} cangrs_header_t;

endpackage

/* testbench/cangrs_chk.sv */
// Port checker of the CAN general register set.
`timescale 1ns/1ps
`include "cangrs_consts.svh"
module cangrs_chk
	import cangrs_pkg::*;
(
	input wire logic           pclk,
	input wire logic           presetn,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [11:0]    paddr,
	input wire logic [31:0]    pwdata,
	input wire logic [31:0]    prdata,
	input wire logic           pready,
	input wire logic           pslverr,
	input wire cangrs_events_t core_events,
	input wire logic [8:0]     tx_error_count,
	input wire logic           irq,
	input wire logic [3:0]     segment_one_len,
	input wire logic [2:0]     segment_two_len,
	input wire logic           core_running
);
	// Access decode and a shadow of the enables, so irq is judged without a read.
	wire        acc = psel & penable;
	logic [7:0] en_q;
	logic       run_q;

	// The shadows take a write at the same edge as the registers themselves.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q  <= 8'h00;
			run_q <= 1'b0;
		end else if (acc && pwrite) begin
			if (paddr == `CANGRS_OFF_ENABLES)
				en_q <= pwdata[7:0];
			if (paddr == `CANGRS_OFF_CTRL)
				run_q <= pwdata[`CANGRS_BIT_RUN];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Bus steps that several properties share.
	sequence seg_wr;
		acc && pwrite && paddr == `CANGRS_OFF_SEGTIME;
	endsequence
	sequence ctl_rd;
		acc && !pwrite && paddr == `CANGRS_OFF_CTRL;
	endsequence
	// Real standby: run low for two edges and not running, which leaves out resync.
	sequence seg_wr_idle;
		seg_wr ##0 !core_running && !run_q && !$past(run_q);
	endsequence

	pend_or_a: assert property (acc && !pwrite && paddr == `CANGRS_OFF_FLAGS |-> prdata[0] == |prdata[3:1])
		else $error("Pending bit differs from the error flags.");
	rsvd_zero_a: assert property (ctl_rd |-> prdata[31:7] == 25'h0)
		else $error("Reserved control bits read nonzero.");
	txdone_irq_a: assert property (core_events.tx_done && en_q[4] |=> irq)
		else $error("Transmit done did not raise irq.");
	txerr_irq_a: assert property (core_events.tx_error && en_q[1] |=> irq)
		else $error("Transmit error did not raise irq.");
	ovr_irq_a: assert property (core_events.overrun && en_q[2] |=> irq)
		else $error("Overrun did not raise irq.");
	masked_irq_a: assert property (en_q[5:1] == 5'h00 |-> !irq)
		else $error("Irq raised with all enables clear.");
	seg_hold_a: assert property (seg_wr ##0 core_running |=> $stable({segment_two_len, segment_one_len}))
		else $error("Segment timing changed while running.");
	seg_take_a: assert property (seg_wr_idle |=> {segment_two_len, segment_one_len} == $past(pwdata[6:0]))
		else $error("Segment timing not taken in standby.");
	bus_off_a: assert property (ctl_rd ##0 tx_error_count >= 9'h100 && $past(tx_error_count) >= 9'h100 |-> prdata[6:5] == 2'h2)
		else $error("Bus-off status wrong.");
	passive_a: assert property (ctl_rd ##0 tx_error_count inside {[9'h080:9'h0FF]} && $stable(tx_error_count) |-> prdata[6:5] == 2'h1)
		else $error("Error-passive status wrong.");
endmodule

/* testbench/cangrs_node_model.sv */
// Behavioural model of the protocol core and the other nodes on the bus.
`timescale 1ns/1ps
module cangrs_node_model
	import cangrs_pkg::*;
(
	input  wire logic      pclk,
	output cangrs_events_t ev,
	output logic           hv,
	output cangrs_header_t hdr,
	output logic           own,
	output logic           busy,
	output logic           tick,
	output logic           rec,
	output logic [8:0]     tec,
	output logic           lost,
	output logic           ferr
);
	// Quiet bus and clean counters until a task says otherwise.
	initial {ev, hv, hdr, own, busy, tick, rec, tec, lost, ferr} = '0;

	// One-cycle event pulse, then a settling cycle.
	task automatic pulse(input cangrs_events_t e);
		@(posedge pclk);
		ev <= e;
		@(posedge pclk);
		ev <= '0;
		@(posedge pclk);
	endtask

	// Header strobe; the header lines scramble once released so stale data cannot pass.
	task automatic frame(input cangrs_header_t h);
		@(posedge pclk);
		hdr <= h;
		hv <= 1'b1;
		@(posedge pclk);
		hdr <= ~h;
		hv <= 1'b0;
		@(posedge pclk);
	endtask

	// Bit times of one level; between ticks the line shows the inverse level.
	task automatic bits(input int n, input logic r);
		repeat (n) begin
			repeat (3) @(posedge pclk);
			rec <= r;
			tick <= 1'b1;
			@(posedge pclk);
			rec <= ~r;
			tick <= 1'b0;
		end
		@(posedge pclk);
	endtask

	// Transfer activity and error count as the core would report them.
	task automatic level(input logic b, input logic [8:0] t);
		@(posedge pclk);
		busy <= b;
		tec <= t;
		repeat (2) @(posedge pclk);
	endtask

	// Own-frame marker and retry causes as levels, held while the bench looks.
	task automatic cause(input logic o, input logic l, input logic f);
		@(posedge pclk);
		own <= o;
		lost <= l;
		ferr <= f;
		@(posedge pclk);
	endtask
endmodule

/* testbench/tb_cangrs_top.sv */
// Self-checking bench of the CAN general register set.
`timescale 1ns/1ps
`include "cangrs_consts.svh"
module tb_cangrs_top
	import cangrs_pkg::*;
;
	logic           pclk = 1'b0;
	logic           presetn = 1'b0;
	logic           psel = 1'b0;
	logic           penable = 1'b0;
	logic           pwrite = 1'b0;
	logic [11:0]    paddr = 12'h000;
	logic [31:0]    pwdata = 32'h0;
	logic [31:0]    prdata;
	logic           pready, pslverr, irq, qt, run, wake, hv, own, busy, tick, rec, lost, ferr, bacc, keep, retry;
	logic [1:0]     sjw, se;
	logic [3:0]     s1;
	logic [2:0]     s2, page;
	logic [8:0]     tec;
	cangrs_events_t ev;
	cangrs_header_t hdr;
	int             err_count = 0, checked = 0, cyc = 0, n;
	logic [11:0]    ra [6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014};
	logic [7:0]     rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h23, 8'h00};
	logic [7:0]     evt [5] = '{8'h08, 8'h02, 8'h01, 8'h10, 8'h20};

	always #25 pclk = ~pclk;

	cangrs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_events(ev), .frame_header_valid(hv), .frame_header(hdr), .own_frame(own),
		.transfer_busy(busy), .bus_bit_tick(tick), .bus_recessive(rec), .tx_error_count(tec),
		.tx_lost_arbitration(lost), .tx_failed_error(ferr), .irq(irq), .quantum_tick(qt),
		.sync_jump_width(sjw), .segment_one_len(s1), .segment_two_len(s2), .bank_page(page),
		.bank_access(bacc), .core_running(run), .wake_dominant(wake), .self_receive_keep(keep), .tx_retry(retry));
	cangrs_node_model m (.pclk(pclk), .ev(ev), .hv(hv), .hdr(hdr), .own(own), .busy(busy),
		.tick(tick), .rec(rec), .tec(tec), .lost(lost), .ferr(ferr));

	// One APB transfer; the request is held until pready is seen at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		se = {pslverr, bacc};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		apb(1'b1, a, {24'h0, d}, r);
	endtask

	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(r, {24'h0, e});
	endtask

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// A hang is cut well past the longest sequence, the slow resync wait.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			stop_test;
		end
	end

	// Main sequence; flags are always cleared by immediate masks, never read-modify-write.
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) rc(ra[i], rv[i]);
		$display("Reset values test done");
		m.pulse(8'h04);
		rc(`CANGRS_OFF_FLAGS, 8'h00);
		m.pulse(8'hFB);
		chk({31'h0, irq}, 32'h0);
		rc(`CANGRS_OFF_FLAGS, 8'hFF);
		wr(`CANGRS_OFF_FLAGS, 8'hFF);
		rc(`CANGRS_OFF_FLAGS, 8'hFF);
		wr(`CANGRS_OFF_FLAGS, 8'hFB);
		rc(`CANGRS_OFF_FLAGS, 8'hFB);
		wr(`CANGRS_OFF_FLAGS, 8'hF5);
		rc(`CANGRS_OFF_FLAGS, 8'hF0);
		wr(`CANGRS_OFF_FLAGS, 8'hDF);
		rc(`CANGRS_OFF_BUF_RDY, 8'h06);
		wr(`CANGRS_OFF_BUF_RDY, 8'h05);
		rc(`CANGRS_OFF_FLAGS, 8'h90);
		wr(`CANGRS_OFF_ENABLES, 8'hC1);
		rc(`CANGRS_OFF_ENABLES, 8'h40);
		wr(`CANGRS_OFF_FLAGS, 8'h00);
		m.pulse(8'h04);
		rc(`CANGRS_OFF_FLAGS, 8'h09);
		$display("Flags test done");
		for (int i = 0; i < 5; i++) begin
			wr(`CANGRS_OFF_ENABLES, 8'h02 << i);
			wr(`CANGRS_OFF_FLAGS, 8'h00);
			m.pulse(evt[i]);
			chk({31'h0, irq}, 32'h1);
			wr(`CANGRS_OFF_FLAGS, 8'h00);
			chk({31'h0, irq}, 32'h0);
		end
		$display("Interrupt test done");
		m.frame(16'hB478);
		m.pulse(8'h02);
		rc(`CANGRS_OFF_LID_HIGH, 8'hB4);
		rc(`CANGRS_OFF_LID_LOW, 8'h78);
		for (int i = 0; i < 8; i++) begin
			wr(`CANGRS_OFF_BANK, 8'hF8 | i[7:0]);
			chk({29'h0, page}, i);
		end
		rc(`CANGRS_OFF_BANK, 8'h07);
		rc(12'h030, 8'h00);
		chk({30'h0, se}, 32'h2);
		rc(12'h040, 8'h00);
		chk({30'h0, se}, 32'h1);
		wr(`CANGRS_OFF_CTRL, 8'h18);
		m.cause(1'b1, 1'b0, 1'b1);
		chk({30'h0, keep, retry}, 32'h2);
		m.cause(1'b1, 1'b1, 1'b1);
		chk({30'h0, keep, retry}, 32'h3);
		wr(`CANGRS_OFF_CTRL, 8'h00);
		m.cause(1'b1, 1'b0, 1'b1);
		chk({30'h0, keep, retry}, 32'h1);
		m.cause(1'b0, 1'b0, 1'b0);
		$display("Identifier and bank test done");
		wr(`CANGRS_OFF_PRESCALE, 8'hC1);
		chk({30'h0, sjw}, 32'h3);
		wr(`CANGRS_OFF_SEGTIME, 8'h45);
		chk({25'h0, s2, s1}, 32'h45);
		wr(`CANGRS_OFF_CTRL, 8'h07);
		@(posedge pclk);
		chk({31'h0, wake}, 32'h1);
		m.bits(1, 1'b0);
		m.bits(10, 1'b1);
		chk({31'h0, run}, 32'h0);
		m.bits(1, 1'b1);
		chk({31'h0, run}, 32'h1);
		n = 0;
		repeat (20) begin
			@(posedge pclk);
			n += qt;
		end
		chk(n, 32'hA);
		wr(`CANGRS_OFF_SEGTIME, 8'h12);
		wr(`CANGRS_OFF_PRESCALE, 8'h3F);
		rc(`CANGRS_OFF_SEGTIME, 8'h45);
		rc(`CANGRS_OFF_PRESCALE, 8'hC1);
		wr(`CANGRS_OFF_FLAGS, 8'h00);
		m.level(1'b0, 9'h0C8);
		rc(`CANGRS_OFF_CTRL, 8'h27);
		rc(`CANGRS_OFF_FLAGS, 8'h09);
		m.level(1'b1, 9'h000);
		wr(`CANGRS_OFF_CTRL, 8'h04);
		rc(`CANGRS_OFF_CTRL, 8'h05);
		m.level(1'b0, 9'h12C);
		rc(`CANGRS_OFF_CTRL, 8'h44);
		m.level(1'b0, 9'h000);
		$display("Timing and run test done");
		wr(`CANGRS_OFF_CTRL, 8'h01);
		m.bits(1407, 1'b1);
		chk({31'h0, run}, 32'h0);
		m.bits(1, 1'b1);
		chk({31'h0, run}, 32'h1);
		$display("Slow resync test done");
		stop_test;
	end
endmodule

bind cangrs_top cangrs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.core_events(core_events), .tx_error_count(tx_error_count), .irq(irq), .segment_one_len(segment_one_len),
	.segment_two_len(segment_two_len), .core_running(core_running));
